//--- rtl/monctl_pkg.sv
// Constants for the monitoring control byte and status word.
// Assumes an external serial slave that presents byte-wide register accesses.
// Summary of operation
// - Reboot bit: outputs off, reload, restart later
// - Clear bit holds accumulator and ticks zero
// - Freeze bit stops accumulator and ticks
// - Persist logs to nonvolatile on fault rise
// - Gate level bit read-only, zero above 8V
// - Single-shot rewrite runs one conversion
// - Status word read-only, writes ignored
// - Status bit 7 shows switches commanded on
// - Cool-down bits for degraded switch, overcurrent
// - Shorted switch bit from converter measurements
// - Status bit 4 shows enable pin
// - Status bit 3 shows output good
// - Undervoltage and overvoltage input flags
// - Aux pins and alert pin levels
// - Nonvolatile busy high during writes
// - Converter idle only in single-shot idle
// - Tick counter wrap flag
// - Accumulator wrap flag
// - Tick counts each accumulating conversion
package monctl_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h1D;
  localparam logic [7:0] STAT_LO_ADDR   = 8'h1E;
  localparam logic [7:0] STAT_HI_ADDR   = 8'h1F;
  localparam logic [7:0] FAULT_LOG_ADDR = 8'h04;
  localparam logic [7:0] ALERT_LOG_ADDR = 8'h05;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CTRL_WMASK     = 8'hE5;
  localparam int B_REBOOT   = 7;
  localparam int B_CLEAR    = 6;
  localparam int B_FREEZE   = 5;
  localparam int B_PERSIST  = 2;
  localparam int B_GATE     = 1;
  localparam int B_SINGLE   = 0;
  localparam int CLK_HZ     = 100_000_000;
  localparam int RESTART_MS = 3200;
  localparam int RESTART_CYCLES = (CLK_HZ / 1000) * RESTART_MS;
  localparam int ENERGY_W   = 48;
  localparam int TICK_W     = 32;
  typedef enum logic [1:0] {
    NV_IDLE  = 2'b00,
    NV_FAULT = 2'b01,
    NV_ALERT = 2'b10
  } nv_state_e;
endpackage

//--- rtl/wrap_counter.sv
// Saturating-flag wrap counter with clear and hold.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module wrap_counter #(
  parameter int W = 32
) (
  input  wire logic         core_clk_in,  // System clock.
  input  wire logic         resetn_in,    // Async reset, active low.
  input  wire logic         clear_in,     // Hold at zero.
  input  wire logic         hold_in,      // Keep value.
  input  wire logic         step_in,      // Add once.
  input  wire logic [W-1:0] amount_in,    // Increment.
  output logic      [W-1:0] count_out,    // Count.
  output logic              wrap_out      // Overflowed.
);
  logic [W:0] sum_next;

  assign sum_next = {1'b0, count_out} + {1'b0, amount_in};

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= '0;
    end else if (clear_in) begin
      count_out <= '0;
    end else if (step_in && !hold_in) begin
      count_out <= sum_next[W-1:0];
    end
  end

  // The wrap flag is sticky; clearing the counter clears it too.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wrap_out <= 1'b0;
    end else if (clear_in) begin
      wrap_out <= 1'b0;
    end else if (step_in && !hold_in && sum_next[W]) begin
      wrap_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- rtl/monitor_adc_control_status.sv
// Control byte and status word of the monitoring section.
// Assumes the serial slave gives one-cycle write and read strobes with a
// byte address; status inputs are synchronous levels from the analog side.
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_control_status #(
  parameter int RESTART_CYCLES = monctl_pkg::RESTART_CYCLES,
  parameter int ENERGY_W       = monctl_pkg::ENERGY_W,
  parameter int TICK_W         = monctl_pkg::TICK_W
) (
  input  wire logic                core_clk_in,          // 100 MHz clock.
  input  wire logic                resetn_in,            // Async reset, low.
  input  wire logic [7:0]          reg_addr_in,          // Register address.
  input  wire logic                reg_wr_in,            // Write strobe.
  input  wire logic [7:0]          reg_wdata_in,         // Write data.
  input  wire logic                reg_rd_in,            // Read strobe.
  output logic      [7:0]          reg_rdata_out,        // Read data.
  input  wire logic                switch_on_in,         // Switches commanded on.
  input  wire logic                degraded_switch_cooldown_in, // Cool-down.
  input  wire logic                shorted_switch_seen_in, // Short detected.
  input  wire logic                enable_pin_in,        // Enable pin.
  input  wire logic                output_good_in,       // Output good.
  input  wire logic                overcurrent_cooldown_in, // Cool-down.
  input  wire logic                input_low_flag_in,    // Undervoltage.
  input  wire logic                input_high_flag_in,   // Overvoltage.
  input  wire logic [2:0]          aux_pin_level_in,     // Aux pins 3..1.
  input  wire logic                alert_pin_level_in,   // Alert pin.
  input  wire logic                gate_a_high_in,       // Gate A above 8V.
  input  wire logic                gate_b_high_in,       // Gate B above 8V.
  input  wire logic [7:0]          fault_bits_in,        // Fault log bits.
  input  wire logic [7:0]          fault_log_in,         // Fault log value.
  input  wire logic [7:0]          alert_log_in,         // Alert log value.
  input  wire logic                conv_done_in,         // Conversion finished.
  input  wire logic [ENERGY_W-1:0] power_in,             // Power sample.
  input  wire logic                nv_ready_in,          // Memory takes a byte.
  input  wire logic                nv_done_in,           // Memory write done.
  output logic                     nv_wr_out,            // Memory write pulse.
  output logic      [7:0]          nv_addr_out,          // Memory address.
  output logic      [7:0]          nv_data_out,          // Memory data.
  output logic                     outputs_off_out,      // Force switches off.
  output logic                     reload_defaults_out,  // Reload pulse.
  output logic                     restart_out,          // Restart pulse.
  output logic                     conv_run_out,         // Converter may run.
  output logic      [ENERGY_W-1:0] energy_out,           // Accumulator.
  output logic      [TICK_W-1:0]   ticks_out             // Tick counter.
);
  logic [7:0]  ctrl_reg;
  logic        gate_level_reg;
  logic [7:0]  faults_prev_reg;
  logic        oneshot_reg;
  logic        nv_busy_reg;
  logic        pending_reg;
  logic        rebooting_reg;
  logic [31:0] restart_cnt_reg;
  logic        energy_wrap;
  logic        tick_wrap;
  logic        ctrl_wr;
  logic        accumulate;
  logic        fault_rise;
  logic [15:0] status_word;
  monctl_pkg::nv_state_e nv_state_reg;

  // Writes are decoded for the control address only.
  // The status addresses are never decoded for writes, so they stay read-only.
  // A fault rise is a bit going from 0 to 1 against last cycle's copy.
  // A fault that is already high when logging is enabled starts no save.
  // Only conversions that end while the converter may run are counted.
  assign ctrl_wr    = reg_wr_in && (reg_addr_in == monctl_pkg::CTRL_ADDR);
  assign fault_rise = |(fault_bits_in & ~faults_prev_reg);
  assign accumulate = conv_done_in && conv_run_out;

  ////////////////////////////////////////////////////////////////////////////
  // Control byte.
  // Reserved and gate level bits are masked, so the bus cannot set them.
  // The reboot bit is a one-cycle request that clears itself.
  // The host therefore needs no write of zero before the next reboot.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= monctl_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= reg_wdata_in & monctl_pkg::CTRL_WMASK;
    end else if (ctrl_reg[monctl_pkg::B_REBOOT]) begin
      ctrl_reg[monctl_pkg::B_REBOOT] <= 1'b0;
    end
  end

  // The gate comparators are synchronous levels.
  // One register stage keeps them off the read path.
  // The bit lags the gates by one cycle, far below any polling interval.
  // It reads 0 in the first cycle after reset, before the first sample.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gate_level_reg <= 1'b0;
    end else begin
      gate_level_reg <= !(gate_a_high_in || gate_b_high_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reboot sequence: outputs off, reload pulse, restart after the delay.
  // A request is taken only while no reboot runs.
  // A second request during the wait neither restarts the count
  // nor repeats the reload pulse.
  // The switches stay forced off for the whole wait.
  // The 32-bit counter covers the full delay at this clock.
  // A longer wait needs a wider counter.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rebooting_reg       <= 1'b0;
      restart_cnt_reg     <= '0;
      outputs_off_out     <= 1'b0;
      reload_defaults_out <= 1'b0;
      restart_out         <= 1'b0;
    end else begin
      reload_defaults_out <= 1'b0;
      restart_out         <= 1'b0;
      if (ctrl_reg[monctl_pkg::B_REBOOT] && !rebooting_reg) begin
        rebooting_reg       <= 1'b1;
        outputs_off_out     <= 1'b1;
        reload_defaults_out <= 1'b1;
        restart_cnt_reg     <= '0;
      end else if (rebooting_reg) begin
        if (restart_cnt_reg == 32'(RESTART_CYCLES - 1)) begin
          rebooting_reg   <= 1'b0;
          outputs_off_out <= 1'b0;
          restart_out     <= 1'b1;
        end else begin
          restart_cnt_reg <= restart_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-shot conversion control.
  // A rewrite with the bit still set grants one conversion; clearing it runs free.
  // The first write that sets the bit only stops the converter.
  // A write beats a conversion end in the same cycle.
  // A grant that lands on a conversion end is therefore not lost.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oneshot_reg <= 1'b0;
    end else if (ctrl_wr && reg_wdata_in[monctl_pkg::B_SINGLE] &&
                 ctrl_reg[monctl_pkg::B_SINGLE]) begin
      oneshot_reg <= 1'b1;
    end else if (conv_done_in) begin
      oneshot_reg <= 1'b0;
    end
  end

  // The run level follows the control byte or the grant one cycle later.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_run_out <= 1'b1;
    end else begin
      conv_run_out <= !ctrl_reg[monctl_pkg::B_SINGLE] || oneshot_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy accumulator and tick counter.
  // Both counters share clear and freeze, so they cover the same conversions.
  // Clear beats freeze, and clearing also drops the sticky wrap flags.
  // The tick counter steps on the same strobe that adds a sample.
  wrap_counter #(.W(ENERGY_W)) energy_u (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .clear_in    (ctrl_reg[monctl_pkg::B_CLEAR]),
    .hold_in     (ctrl_reg[monctl_pkg::B_FREEZE]),
    .step_in     (accumulate),
    .amount_in   (power_in),
    .count_out   (energy_out),
    .wrap_out    (energy_wrap)
  );

  wrap_counter #(.W(TICK_W)) tick_u (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .clear_in    (ctrl_reg[monctl_pkg::B_CLEAR]),
    .hold_in     (ctrl_reg[monctl_pkg::B_FREEZE]),
    .step_in     (accumulate),
    .amount_in   (TICK_W'(1)),
    .count_out   (ticks_out),
    .wrap_out    (tick_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Persisting fault logs to nonvolatile memory.
  // The copy resets to zero.
  // A fault that is present at release therefore counts as a rise.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      faults_prev_reg <= 8'h00;
    end else begin
      faults_prev_reg <= fault_bits_in;
    end
  end

  // A rise seen while a save is under way is kept and saved afterwards.
  // The request drops only when a save really starts.
  // A memory that is not ready at the rise still gets the save later.
  // Several rises before the start collapse into one save.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_reg <= 1'b0;
    end else if (fault_rise && ctrl_reg[monctl_pkg::B_PERSIST]) begin
      pending_reg <= 1'b1;
    end else if (nv_state_reg == monctl_pkg::NV_IDLE && nv_ready_in) begin
      pending_reg <= 1'b0;
    end
  end

  // The fault log goes first.
  // The alert log follows once the memory reports the first byte done.
  // Each byte is taken at the moment its write is issued.
  // Busy covers both bytes and falls after the second one.
  // A polling host never sees the memory free between the two writes.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nv_state_reg <= monctl_pkg::NV_IDLE;
      nv_wr_out    <= 1'b0;
      nv_addr_out  <= 8'h00;
      nv_data_out  <= 8'h00;
      nv_busy_reg  <= 1'b0;
    end else begin
      nv_wr_out <= 1'b0;
      case (nv_state_reg)
        monctl_pkg::NV_IDLE: begin
          nv_busy_reg <= 1'b0;
          if (pending_reg && nv_ready_in) begin
            nv_state_reg <= monctl_pkg::NV_FAULT;
            nv_wr_out    <= 1'b1;
            nv_addr_out  <= monctl_pkg::FAULT_LOG_ADDR;
            nv_data_out  <= fault_log_in;
            nv_busy_reg  <= 1'b1;
          end
        end
        monctl_pkg::NV_FAULT: begin
          if (nv_done_in) begin
            nv_state_reg <= monctl_pkg::NV_ALERT;
            nv_wr_out    <= 1'b1;
            nv_addr_out  <= monctl_pkg::ALERT_LOG_ADDR;
            nv_data_out  <= alert_log_in;
          end
        end
        monctl_pkg::NV_ALERT: begin
          if (nv_done_in) begin
            nv_state_reg <= monctl_pkg::NV_IDLE;
            nv_busy_reg  <= 1'b0;
          end
        end
        default: begin
          nv_state_reg <= monctl_pkg::NV_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and read path; the status addresses ignore writes.
  // The status word is built from live levels.
  // A read shows the state at the edge that takes the read strobe.
  // The idle bit is set only in single-shot operation with no grant pending.
  // In free-running operation it always reads 0.
  assign status_word = {
    aux_pin_level_in[2], aux_pin_level_in[1], aux_pin_level_in[0],
    alert_pin_level_in,
    nv_busy_reg,
    ctrl_reg[monctl_pkg::B_SINGLE] && !oneshot_reg,
    tick_wrap, energy_wrap,
    switch_on_in,
    degraded_switch_cooldown_in,
    shorted_switch_seen_in,
    enable_pin_in,
    output_good_in,
    overcurrent_cooldown_in,
    input_low_flag_in, input_high_flag_in
  };

  // Read data hold until the next read; unmapped addresses read as zero.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == monctl_pkg::CTRL_ADDR) begin
        reg_rdata_out <= {ctrl_reg[7:2], gate_level_reg, ctrl_reg[0]};
      end else if (reg_addr_in == monctl_pkg::STAT_LO_ADDR) begin
        reg_rdata_out <= status_word[7:0];
      end else if (reg_addr_in == monctl_pkg::STAT_HI_ADDR) begin
        reg_rdata_out <= status_word[15:8];
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/nv_mem_model.sv
// Behavioural nonvolatile memory that takes one byte write at a time.
// Assumes the block pulses the write strobe only while the ready level is high.
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model (
  input  wire logic core_clk_in,  // Clock.
  input  wire logic resetn_in,    // Reset, active low.
  input  wire logic nv_wr_out,    // Write pulse.
  input  wire logic slow_in,      // Long write time.
  output logic      nv_ready_in,  // Free for a byte.
  output logic      nv_done_in    // Write finished.
);
  logic [3:0] busy_cnt;
  // Ready stays low for the whole write, so the busy flag has a real window.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_cnt <= 4'h0;
      nv_ready_in <= 1'b1;
      nv_done_in <= 1'b0;
    end else begin
      nv_done_in <= 1'b0;
      if (nv_wr_out) begin
        nv_ready_in <= 1'b0;
        busy_cnt <= slow_in ? 4'h8 : 4'h2;
      end else if (busy_cnt == 4'h1) begin
        nv_done_in <= 1'b1;
        nv_ready_in <= 1'b1;
        busy_cnt <= 4'h0;
      end else if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/monitor_ctl_sva.sv
// Port checks for the control byte and status word.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module monitor_ctl_sva #(
  parameter int RESTART_CYCLES = 50,
  parameter int ENERGY_W       = 8,
  parameter int TICK_W         = 4
) (
  input wire logic                core_clk_in,         // Clock.
  input wire logic                resetn_in,           // Reset.
  input wire logic [7:0]          reg_addr_in,         // Address.
  input wire logic                reg_wr_in,           // Write.
  input wire logic [7:0]          reg_wdata_in,        // Write data.
  input wire logic                reg_rd_in,           // Read.
  input wire logic [7:0]          reg_rdata_out,       // Read data.
  input wire logic                gate_a_high_in,      // Gate A high.
  input wire logic                gate_b_high_in,      // Gate B high.
  input wire logic                conv_done_in,        // Conversion end.
  input wire logic                nv_wr_out,           // Memory write.
  input wire logic [7:0]          nv_addr_out,         // Memory address.
  input wire logic                outputs_off_out,     // Switches off.
  input wire logic                reload_defaults_out, // Reload.
  input wire logic                restart_out,         // Restart.
  input wire logic                conv_run_out,        // Converter run.
  input wire logic [ENERGY_W-1:0] energy_out,          // Accumulator.
  input wire logic [TICK_W-1:0]   ticks_out            // Ticks.
);
  logic clr_sh;
  logic frz_sh;
  logic sgl_sh;
  int   since_reload;
  wire  ctrl_wr = reg_wr_in && reg_addr_in == 8'h1D;
  // The control register is not a port, so its mode bits are shadowed here.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clr_sh <= 1'b0;
      frz_sh <= 1'b0;
      sgl_sh <= 1'b0;
    end else if (ctrl_wr) begin
      clr_sh <= reg_wdata_in[6];
      frz_sh <= reg_wdata_in[5];
      sgl_sh <= reg_wdata_in[0];
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) since_reload <= 0;
    else if (reload_defaults_out) since_reload <= 0;
    else since_reload <= since_reload + 1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_reboot_off: assert property (
    ctrl_wr && reg_wdata_in[7] |-> ##[1:3] (outputs_off_out && reload_defaults_out))
    else $error("reboot did not switch off and reload");
  chk_restart_delay: assert property (
    restart_out |-> since_reload >= RESTART_CYCLES - 3 && since_reload <= RESTART_CYCLES + 3)
    else $error("restart at wrong delay");
  chk_clear_hold: assert property (
    clr_sh && $past(clr_sh) |-> energy_out == '0 && ticks_out == '0)
    else $error("counters not held at zero");
  chk_freeze_hold: assert property (
    frz_sh && $past(frz_sh) && !clr_sh && !$past(clr_sh)
      |-> $stable(energy_out) && $stable(ticks_out))
    else $error("counters moved while frozen");
  chk_reserved_zero: assert property (
    reg_rd_in && reg_addr_in == 8'h1D |=> reg_rdata_out[4:3] == 2'h0)
    else $error("reserved control bits not zero");
  chk_gate_level: assert property (
    reg_rd_in && reg_addr_in == 8'h1D && $stable(gate_a_high_in) && $stable(gate_b_high_in)
      |=> reg_rdata_out[1] == !($past(gate_a_high_in) || $past(gate_b_high_in)))
    else $error("gate level bit wrong");
  chk_log_order: assert property (
    nv_wr_out && nv_addr_out == 8'h04 |-> ##[2:20] (nv_wr_out && nv_addr_out == 8'h05))
    else $error("alert log not written after fault log");
  chk_single_stop: assert property (
    sgl_sh && conv_run_out && conv_done_in |-> ##[1:3] !conv_run_out)
    else $error("converter kept running after single shot");
  chk_free_idle: assert property (
    reg_rd_in && reg_addr_in == 8'h1F && !sgl_sh && !$past(sgl_sh) && !$past(sgl_sh, 2)
      |=> !reg_rdata_out[2])
    else $error("idle flag set while free running");
  cov_restart: cover property (restart_out);
  cov_alert_log: cover property (nv_wr_out && nv_addr_out == 8'h05);
  cov_one_shot: cover property (sgl_sh && conv_run_out && conv_done_in);
endmodule
bind monitor_adc_control_status monitor_ctl_sva #(.RESTART_CYCLES(RESTART_CYCLES),
  .ENERGY_W(ENERGY_W), .TICK_W(TICK_W)) i_monitor_ctl_sva (.*);
`default_nettype wire

//--- verif/monitor_adc_control_status_tb.sv
// Self-checking bench for the control byte and status word.
// Assumes short restart and narrow counters so wraps happen quickly.
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_control_status_tb;
  logic core_clk_in, resetn_in, reg_wr_in, reg_rd_in, gate_a_high_in, gate_b_high_in;
  logic alert_pin_level_in, conv_done_in, slow_in, nv_wr_out, outputs_off_out;
  logic reload_defaults_out, restart_out, conv_run_out, nv_ready_in, nv_done_in;
  logic [7:0] reg_addr_in, reg_wdata_in, st_lo, fault_bits_in, fault_log_in, alert_log_in;
  logic [7:0] power_in, reg_rdata_out, nv_addr_out, nv_data_out, energy_out;
  logic [3:0] ticks_out;
  logic [2:0] aux_pin_level_in;
  logic       reload_seen, restart_seen;
  logic [15:0] nvq[$];
  int err_total, num_checks;
  wire switch_on_in, degraded_switch_cooldown_in, shorted_switch_seen_in, enable_pin_in;
  wire output_good_in, overcurrent_cooldown_in, input_low_flag_in, input_high_flag_in;
  assign {switch_on_in, degraded_switch_cooldown_in, shorted_switch_seen_in, enable_pin_in,
          output_good_in, overcurrent_cooldown_in, input_low_flag_in, input_high_flag_in} = st_lo;
  monitor_adc_control_status #(.RESTART_CYCLES(50), .ENERGY_W(8), .TICK_W(4))
    i_monitor_adc_control_status (.*);
  nv_mem_model i_nv_mem_model (.*);
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(negedge core_clk_in) begin
    if (nv_wr_out) nvq.push_back({nv_addr_out, nv_data_out});
    if (reload_defaults_out) reload_seen = 1'b1;
    if (restart_out) restart_seen = 1'b1;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    @(negedge core_clk_in);
    chk(n, e, reg_rdata_out);
  endtask
  task automatic conv(input int n);
    repeat (n) begin
      @(negedge core_clk_in);
      conv_done_in = 1'b1;
      @(negedge core_clk_in);
      conv_done_in = 1'b0;
    end
    ticks(2);
  endtask
  task automatic t_control;
    rdc(8'h1D, 8'h02, "ctrl reset");
    rdc(8'h30, 8'h00, "unmapped");
    gate_a_high_in = 1'b1;
    wr(8'h1D, 8'h1A);
    rdc(8'h1D, 8'h00, "ctrl gate a");
    gate_a_high_in = 1'b0;
    gate_b_high_in = 1'b1;
    rdc(8'h1D, 8'h00, "ctrl gate b");
    gate_b_high_in = 1'b0;
    rdc(8'h1D, 8'h02, "ctrl gate low");
  endtask
  task automatic t_status;
    for (int i = 0; i < 8; i++) begin
      st_lo = 8'h01 << i;
      rdc(8'h1E, 8'h01 << i, "status low bit");
    end
    wr(8'h1E, 8'hFF);
    wr(8'h1F, 8'hFF);
    st_lo = 8'h00;
    aux_pin_level_in = 3'h6;
    alert_pin_level_in = 1'b1;
    rdc(8'h1E, 8'h00, "status low write");
    rdc(8'h1F, 8'hD0, "status high pins");
    aux_pin_level_in = 3'h0;
    alert_pin_level_in = 1'b0;
  endtask
  task automatic t_single;
    wr(8'h1D, 8'h01);
    ticks(3);
    chk("conv run halted", 16'h0, conv_run_out);
    rdc(8'h1F, 8'h04, "idle halted");
    wr(8'h1D, 8'h01);
    ticks(2);
    chk("conv run shot", 16'h1, conv_run_out);
    rdc(8'h1F, 8'h00, "idle during shot");
    conv(1);
    chk("conv run after shot", 16'h0, conv_run_out);
    rdc(8'h1F, 8'h04, "idle after shot");
    wr(8'h1D, 8'h00);
    ticks(3);
    chk("conv run free", 16'h1, conv_run_out);
  endtask
  task automatic t_meter;
    power_in = 8'h10;
    wr(8'h1D, 8'h40);
    conv(2);
    chk("energy cleared", 16'h0, {energy_out, ticks_out});
    wr(8'h1D, 8'h00);
    conv(3);
    chk("energy counted", 16'h303, {energy_out, ticks_out});
    wr(8'h1D, 8'h20);
    conv(2);
    chk("energy frozen", 16'h303, {energy_out, ticks_out});
    wr(8'h1D, 8'h00);
    conv(13);
    rdc(8'h1F, 8'h03, "wrap flags");
    wr(8'h1D, 8'h40);
    rdc(8'h1F, 8'h00, "wrap flags cleared");
    wr(8'h1D, 8'h00);
  endtask
  task automatic t_persist;
    fault_log_in = 8'h5A;
    alert_log_in = 8'hC3;
    fault_bits_in = 8'h01;
    ticks(10);
    chk("no log writes", 16'h0, nvq.size());
    fault_bits_in = 8'h00;
    slow_in = 1'b1;
    wr(8'h1D, 8'h04);
    fault_bits_in = 8'h02;
    ticks(4);
    rdc(8'h1F, 8'h08, "memory busy");
    ticks(30);
    rdc(8'h1F, 8'h00, "memory free");
    chk("fault log write", 16'h045A, nvq[0]);
    chk("alert log write", 16'h05C3, nvq[1]);
    slow_in = 1'b0;
    fault_bits_in = 8'h00;
    ticks(2);
    fault_bits_in = 8'h03;
    ticks(20);
    chk("second alert log", 16'h05C3, nvq[3]);
  endtask
  task automatic t_reboot;
    wr(8'h1D, 8'h80);
    ticks(2);
    chk("outputs off", 16'h3, {outputs_off_out, reload_seen});
    ticks(60);
    chk("restarted", 16'h1, {outputs_off_out, restart_seen});
    rdc(8'h1D, 8'h02, "reboot bit clear");
  endtask
  // Generous limit: the whole sequence needs well under ten thousand cycles.
  initial begin
    #100us;
    err_total++;
    test_done;
  end
  initial begin
    {resetn_in, reg_wr_in, reg_rd_in, gate_a_high_in, gate_b_high_in} = 5'h00;
    {alert_pin_level_in, conv_done_in, slow_in, reload_seen, restart_seen} = 5'h00;
    {reg_addr_in, reg_wdata_in, st_lo, fault_bits_in, fault_log_in} = 40'h0;
    {alert_log_in, power_in, aux_pin_level_in} = 19'h0;
    err_total = 0;
    num_checks = 0;
    ticks(8);
    resetn_in = 1'b1;
    t_control;
    t_status;
    t_single;
    t_meter;
    t_persist;
    t_reboot;
    test_done;
  end
endmodule
`default_nettype wire
